/* verilog/otf_defs.svh */
`ifndef OTF_DEFS_SVH
`define OTF_DEFS_SVH
// command codes of the two registers
`define OTF_CMD_LIMIT 8'h4F
`define OTF_CMD_ACTION 8'h50
// reset values: 100 C in linear format, disable with no retry and delay code 0
`define OTF_LIMIT_RST 16'hEB20
`define OTF_ACTION_RST 8'h80
// response field codes
`define OTF_RESP_IGNORE 2'b00
`define OTF_RESP_CONTINUE 2'b01
`define OTF_RESP_DISABLE 2'b10
`define OTF_RESP_RESUME 2'b11
// retry field codes
`define OTF_RETRY_NONE 3'b000
`define OTF_RETRY_FOREVER 3'b111
`endif

/* verilog/otf_pkg.sv */
package otf_pkg;
   typedef enum logic [2:0] {
      ST_OFF,
      ST_RUN,
      ST_DELAY,
      ST_WAIT,
      ST_HOLD,
      ST_LATCH
   } otf_state_t;

   typedef struct packed {
      logic [1:0] resp;
      logic [2:0] retry;
      logic [2:0] delay;
   } otf_action_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [7:0] code;
      logic [15:0] data;
   } otf_req_t;

   typedef struct packed {
      logic enableCmd;
      logic biasOk;
      logic otherFault;
      logic faultClear;
   } otf_ctl_t;
endpackage

/* verilog/otf_fault_response.sv */
`timescale 1ns/1ps
`include "otf_defs.svh"

// Function
// - threshold register holds a 16-bit linear-format temperature in degrees Celsius.
// - response 00 keeps the output running through an over-temperature fault.
// - response 01 runs on for the delay, then acts per retry if fault remains.
// - response 10 switches the output off at once, then follows the retry field.
// - response 11 keeps output off while the fault lasts, re-enables when gone.
// - retry 000 makes no restart; output stays off until the fault is cleared.
// - retry 001 to 110 tries that many restarts, then stays off until cleared.
// - restart attempts start one delay apart, two to the power of the delay field times the time unit.
// - retry 111 retries forever until commanded off, bias lost, or other fault.
// - delay code n means two to the power n time units, 1 up to 128.
// - unit length comes from a separate register; one delay serves both uses.
module otf_fault_response #(
   parameter int UNIT_W = 24
) (
   // clock and reset
   input wire logic clock,
   input wire logic reset_n,
   // register access by command code
   input wire otf_pkg::otf_req_t regReq,
   output logic [15:0] rdData,
   output logic rdValid,
   output logic rdError,
   // measurement and time unit
   input wire logic [15:0] temperature,
   input wire logic [UNIT_W-1:0] unitCycles,
   // power control
   input wire otf_pkg::otf_ctl_t ctl,
   // status and output control
   output logic outputEnable,
   output logic faultSeen,
   output logic faultLatched,
   output logic [2:0] retryCount
);
   import otf_pkg::*;

   // linear format to signed fixed point with 16 fraction bits
   function automatic logic signed [47:0] linToFix(input logic [15:0] v);
      logic signed [47:0] m;
      logic [4:0] sh;
      m = {{37{v[10]}}, v[10:0]};
      sh = {~v[15], v[14:11]};
      linToFix = m <<< sh;
   endfunction

   function automatic logic [7:0] delayUnits(input logic [2:0] code);
      delayUnits = 8'h01 << code;
   endfunction

   logic [15:0] limit_ff;
   otf_action_t action_ff;
   otf_state_t state_ff;
   otf_state_t nxt_state;
   logic overTemp_ff;
   logic [UNIT_W-1:0] unitCnt_ff;
   logic [7:0] unitsDone_ff;
   logic [2:0] retryCnt_ff;
   logic [15:0] rdData_ff;
   logic rdValid_ff;
   logic rdError_ff;
   logic outputEnable_ff;
   logic faultSeen_ff;
   logic faultLatched_ff;
   logic stopReq;
   logic timerRun;
   logic unitTick;
   logic expire;
   logic moreRetries;
   logic [15:0] wrData;

   assign wrData = regReq.data;
   assign stopReq = !ctl.enableCmd || !ctl.biasOk || ctl.otherFault;
   assign timerRun = (state_ff == ST_DELAY) || (state_ff == ST_WAIT);
   assign unitTick = (UNIT_W'(unitCnt_ff + 1'b1) >= unitCycles);
   assign expire = timerRun && unitTick &&
      (unitsDone_ff == 8'(delayUnits(action_ff.delay) - 8'h01));
   assign moreRetries = (action_ff.retry == `OTF_RETRY_FOREVER) ||
      ({1'b0, retryCnt_ff} + 4'h1 < {1'b0, action_ff.retry});

   // register writes
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         limit_ff <= `OTF_LIMIT_RST;
         action_ff <= `OTF_ACTION_RST;
      end else if (regReq.wr) begin
         if (regReq.code == `OTF_CMD_LIMIT) begin
            limit_ff <= wrData;
         end
         if (regReq.code == `OTF_CMD_ACTION) begin
            action_ff <= wrData[7:0];
         end
      end
   end

   // register reads, answered one cycle later
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         rdData_ff <= 16'h0000;
         rdValid_ff <= 1'b0;
         rdError_ff <= 1'b0;
      end else begin
         rdValid_ff <= regReq.rd;
         rdError_ff <= 1'b0;
         rdData_ff <= 16'h0000;
         if (regReq.rd) begin
            case (regReq.code)
               `OTF_CMD_LIMIT: rdData_ff <= limit_ff;
               `OTF_CMD_ACTION: rdData_ff <= {8'h00, action_ff};
               default: rdError_ff <= 1'b1;
            endcase
         end
      end
   end

   // fault detection
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         overTemp_ff <= 1'b0;
      end else begin
         overTemp_ff <= (linToFix(temperature) >= linToFix(limit_ff));
      end
   end

   // sticky fault status, a new fault wins over a clear
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         faultSeen_ff <= 1'b0;
      end else if (overTemp_ff) begin
         faultSeen_ff <= 1'b1;
      end else if (ctl.faultClear) begin
         faultSeen_ff <= 1'b0;
      end
   end

   // delay timer, restarted on entry to a timed state and at each expiry
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         unitCnt_ff <= '0;
         unitsDone_ff <= 8'h00;
      end else if (!timerRun || expire) begin
         unitCnt_ff <= '0;
         unitsDone_ff <= 8'h00;
      end else if (unitTick) begin
         unitCnt_ff <= '0;
         unitsDone_ff <= unitsDone_ff + 8'h01;
      end else begin
         unitCnt_ff <= unitCnt_ff + 1'b1;
      end
   end

   // failed restart attempts
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         retryCnt_ff <= 3'h0;
      end else if (state_ff != ST_WAIT) begin
         retryCnt_ff <= 3'h0;
      end else if (expire && overTemp_ff && moreRetries &&
                   retryCnt_ff != `OTF_RETRY_FOREVER) begin
         retryCnt_ff <= retryCnt_ff + 3'h1;
      end
   end

   always_comb begin
      nxt_state = state_ff;
      case (state_ff)
         ST_OFF: begin
            nxt_state = ST_RUN;
         end
         ST_RUN: begin
            if (overTemp_ff) begin
               case (action_ff.resp)
                  `OTF_RESP_IGNORE: nxt_state = ST_RUN;
                  `OTF_RESP_CONTINUE: nxt_state = ST_DELAY;
                  `OTF_RESP_DISABLE: begin
                     nxt_state = (action_ff.retry == `OTF_RETRY_NONE) ? ST_LATCH : ST_WAIT;
                  end
                  default: nxt_state = ST_HOLD;
               endcase
            end
         end
         ST_DELAY: begin
            if (!overTemp_ff) begin
               nxt_state = ST_RUN;
            end else if (expire) begin
               nxt_state = (action_ff.retry == `OTF_RETRY_NONE) ? ST_LATCH : ST_WAIT;
            end
         end
         ST_WAIT: begin
            if (expire) begin
               if (!overTemp_ff) begin
                  nxt_state = ST_RUN;
               end else if (!moreRetries) begin
                  nxt_state = ST_LATCH;
               end
            end
         end
         ST_HOLD: begin
            if (!overTemp_ff) begin
               nxt_state = ST_RUN;
            end
         end
         ST_LATCH: begin
            if (ctl.faultClear && !overTemp_ff) begin
               nxt_state = ST_RUN;
            end
         end
         default: nxt_state = ST_OFF;
      endcase
      if (stopReq) begin
         nxt_state = ST_OFF;
      end
   end

   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= ST_OFF;
         outputEnable_ff <= 1'b0;
         faultLatched_ff <= 1'b0;
      end else begin
         state_ff <= nxt_state;
         outputEnable_ff <= (nxt_state == ST_RUN) || (nxt_state == ST_DELAY);
         faultLatched_ff <= (nxt_state == ST_LATCH);
      end
   end

   assign rdData = rdData_ff;
   assign rdValid = rdValid_ff;
   assign rdError = rdError_ff;
   assign outputEnable = outputEnable_ff;
   assign faultSeen = faultSeen_ff;
   assign faultLatched = faultLatched_ff;
   assign retryCount = retryCnt_ff;

   // cycles since the timer started, read only by the checks
   int waitCyc_ff;
   always_ff @(posedge clock or negedge reset_n) begin
      if (!reset_n) begin
         waitCyc_ff <= 0;
      end else if (!timerRun || expire) begin
         waitCyc_ff <= 0;
      end else begin
         waitCyc_ff <= waitCyc_ff + 1;
      end
   end

   default clocking cb @(posedge clock);
   endclocking
   default disable iff (!reset_n);

   limit_readback_a: assert property (
      (regReq.wr && regReq.code == `OTF_CMD_LIMIT) ##1 !regReq.wr ##1
         (regReq.rd && !regReq.wr && regReq.code == `OTF_CMD_LIMIT)
      |=> rdValid && rdData == $past(wrData, 3))
      else $error("threshold readback differs from written value");
   ignore_stays_on_a: assert property (
      (state_ff == ST_RUN && action_ff.resp == `OTF_RESP_IGNORE && overTemp_ff && !stopReq)
      |=> outputEnable ##0 state_ff == ST_RUN)
      else $error("ignore response interrupted the output");
   continue_on_a: assert property (
      (state_ff == ST_RUN && action_ff.resp == `OTF_RESP_CONTINUE && overTemp_ff && !stopReq)
      |=> state_ff == ST_DELAY && outputEnable)
      else $error("continue response did not keep output on");
   disable_now_a: assert property (
      (state_ff == ST_RUN && action_ff.resp == `OTF_RESP_DISABLE && overTemp_ff)
      |=> !outputEnable)
      else $error("disable response left output on");
   resume_when_ok_a: assert property (
      (state_ff == ST_HOLD && !overTemp_ff && !stopReq) |=> outputEnable ##0 state_ff == ST_RUN)
      else $error("output not resumed after fault went away");
   latch_holds_a: assert property (
      (state_ff == ST_LATCH && !ctl.faultClear && !stopReq) |=> state_ff == ST_LATCH && !outputEnable)
      else $error("latched-off state left without a clear");
   // holds while the retry field is left alone during a running sequence
   retry_limit_a: assert property (
      (state_ff == ST_WAIT && action_ff.retry != `OTF_RETRY_FOREVER)
      |-> {1'b0, retryCnt_ff} < {1'b0, action_ff.retry})
      else $error("more restart attempts than programmed");
   delay_length_a: assert property (
      expire |-> waitCyc_ff == int'(delayUnits(action_ff.delay)) *
         ((unitCycles == '0) ? 1 : int'(unitCycles)) - 1)
      else $error("delay length wrong");
   retry_forever_a: assert property (
      (state_ff == ST_WAIT && expire && overTemp_ff && !stopReq && action_ff.retry == `OTF_RETRY_FOREVER)
      |=> state_ff == ST_WAIT)
      else $error("continuous retry stopped");
   stop_forces_off_a: assert property (
      stopReq |=> state_ff == ST_OFF && !outputEnable)
      else $error("output on while commanded off");
   fault_detect_a: assert property (
      $rose(overTemp_ff) |-> $past(linToFix(temperature) >= linToFix(limit_ff)))
      else $error("fault flagged below threshold");
   // same-exponent pairs compare by mantissa alone, independent of the converter
   fault_compare_a: assert property (
      $past(temperature[15:11] == limit_ff[15:11]) |->
         overTemp_ff == $past($signed(temperature[10:0]) >= $signed(limit_ff[10:0])))
      else $error("fault flag disagrees with mantissa compare");
endmodule

/* sim/otf_host_model.sv */
`timescale 1ns/1ps
module otf_host_model (
   // clock
   input wire logic clock,
   // register port
   output otf_pkg::otf_req_t regReq,
   input wire logic [15:0] rdData,
   input wire logic rdValid,
   input wire logic rdError
);
   import otf_pkg::*;
   initial regReq = '0;
   // one strobe cycle per access; a released bus drops both strobes and shows the inverse of its last code and data
   task automatic access(input logic wr, input logic [7:0] code, input logic [15:0] data,
                         output logic [15:0] got, output logic vld, output logic err);
      @(posedge clock);
      regReq <= '{wr: wr, rd: !wr, code: code, data: data};
      @(posedge clock);
      regReq <= '{wr: 1'b0, rd: 1'b0, code: ~code, data: ~data};
      #1;
      got = rdData;
      vld = rdValid;
      err = rdError;
   endtask
endmodule

/* sim/test_otf_fault_response.sv */
`timescale 1ns/1ps
`include "otf_defs.svh"
module test_otf_fault_response;
   import otf_pkg::*;
   localparam int UNIT = 4;
   logic clock = 1'b0;
   logic reset_n = 1'b0;
   otf_req_t regReq;
   logic [15:0] rdData;
   logic [15:0] temperature = 16'h0000;
   logic rdValid, rdError, outputEnable, faultSeen, faultLatched, vld, err;
   logic [2:0] retryCount;
   logic [23:0] unitCycles = 24'(UNIT);
   otf_ctl_t ctl = '{enableCmd: 1'b1, biasOk: 1'b1, otherFault: 1'b0, faultClear: 1'b0};
   logic [15:0] got;
   int n_mismatch = 0;
   int num_checks = 0;
   int n;
   always #2.5 clock = ~clock;
   otf_fault_response i_otf_fault_response (.clock(clock), .reset_n(reset_n), .regReq(regReq),
      .rdData(rdData), .rdValid(rdValid), .rdError(rdError), .temperature(temperature),
      .unitCycles(unitCycles), .ctl(ctl), .outputEnable(outputEnable), .faultSeen(faultSeen),
      .faultLatched(faultLatched), .retryCount(retryCount));
   otf_host_model i_otf_host_model (.clock(clock), .regReq(regReq), .rdData(rdData),
      .rdValid(rdValid), .rdError(rdError));
   task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", what, exp, seen);
      end
   endtask
   task automatic rd_chk(input logic [7:0] code, input logic [15:0] exp, input logic expErr);
      i_otf_host_model.access(1'b0, code, 16'h0000, got, vld, err);
      check("rdValid", 16'(vld), 16'h0001);
      check("rdError", 16'(err), 16'(expErr));
      check("rdData", got, exp);
   endtask
   task automatic wr(input logic [7:0] code, input logic [15:0] data);
      i_otf_host_model.access(1'b1, code, data, got, vld, err);
   endtask
   task automatic cycles(input int k);
      repeat (k) @(posedge clock);
      #1;
   endtask
   // counts edges until the watched output reaches the level
   task automatic wait_for(input bit latch, input logic lvl, output int cnt);
      cnt = 0;
      while (((latch ? faultLatched : outputEnable) !== lvl) && cnt < 5000) begin
         @(posedge clock);
         #1;
         cnt++;
      end
      check("wait", 16'(cnt < 5000), 16'h0001);
   endtask
   task automatic in_range(input int v, input int lo, input int hi);
      check("cycles", 16'(v >= lo && v <= hi), 16'h0001);
   endtask
   task automatic heat(input logic [15:0] t);
      @(posedge clock);
      temperature <= t;
   endtask
   task automatic recover();
      heat(16'h0063);
      @(posedge clock);
      ctl.faultClear <= 1'b1;
      @(posedge clock);
      ctl.faultClear <= 1'b0;
      wait_for(1'b0, 1'b1, n);
   endtask
   task automatic print_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask
   initial begin
      #200000;
      n_mismatch++;
      print_verdict();
   end
   initial begin
      repeat (8) @(posedge clock);
      reset_n <= 1'b1;
      rd_chk(`OTF_CMD_LIMIT, `OTF_LIMIT_RST, 1'b0);
      rd_chk(`OTF_CMD_ACTION, 16'h0080, 1'b0);
      rd_chk(8'h51, 16'h0000, 1'b1);
      wr(8'h51, 16'h1234);
      wr(`OTF_CMD_LIMIT, 16'h0064);
      rd_chk(`OTF_CMD_LIMIT, 16'h0064, 1'b0);
      wr(`OTF_CMD_ACTION, 16'hFF00);
      rd_chk(`OTF_CMD_ACTION, 16'h0000, 1'b0);
      heat(16'h0064);
      cycles(20);
      check("faultSeen", 16'(faultSeen), 16'h0001);
      check("outputEnable", 16'(outputEnable), 16'h0001);
      wr(`OTF_CMD_ACTION, 16'h00C0);
      wait_for(1'b0, 1'b0, n);
      in_range(n, 1, 3);
      heat(16'h0063);
      wait_for(1'b0, 1'b1, n);
      in_range(n, 2, 3);
      wr(`OTF_CMD_ACTION, 16'h0080);
      heat(16'h0064);
      wait_for(1'b0, 1'b0, n);
      in_range(n, 2, 2);
      wait_for(1'b1, 1'b1, n);
      in_range(n, 0, 2);
      heat(16'h0063);
      cycles(10);
      check("outputEnable", 16'(outputEnable), 16'h0000);
      recover();
      check("faultSeen", 16'(faultSeen), 16'h0000);
      for (int r = 1; r <= 6; r++) begin
         wr(`OTF_CMD_ACTION, 16'(8'h80 | (r << 3) | (r - 1)));
         heat(16'h0064);
         wait_for(1'b0, 1'b0, n);
         in_range(n, 2, 2);
         cycles(UNIT << (r - 1));
         check("retryCount", 16'(retryCount), 16'(r > 1));
         wait_for(1'b1, 1'b1, n);
         in_range(n, (r - 1) * (UNIT << (r - 1)), (r - 1) * (UNIT << (r - 1)) + 1);
         check("outputEnable", 16'(outputEnable), 16'h0000);
         recover();
      end
      @(posedge clock);
      unitCycles <= 24'h000002;
      wr(`OTF_CMD_ACTION, 16'h0047);
      heat(16'h0064);
      wait_for(1'b0, 1'b0, n);
      in_range(n, 258, 259);
      recover();
      wr(`OTF_CMD_ACTION, 16'h0048);
      heat(16'h0064);
      wait_for(1'b0, 1'b0, n);
      in_range(n, 4, 4);
      wait_for(1'b1, 1'b1, n);
      in_range(n, 2, 2);
      recover();
      wr(`OTF_CMD_ACTION, 16'h009A);
      heat(16'h0064);
      wait_for(1'b0, 1'b0, n);
      heat(16'h0063);
      wait_for(1'b0, 1'b1, n);
      in_range(n, 5, 9);
      wr(`OTF_CMD_ACTION, 16'h00B8);
      heat(16'h0064);
      cycles(100);
      check("faultLatched", 16'(faultLatched), 16'h0000);
      check("outputEnable", 16'(outputEnable), 16'h0000);
      @(posedge clock);
      ctl.enableCmd <= 1'b0;
      heat(16'h0063);
      cycles(5);
      check("outputEnable", 16'(outputEnable), 16'h0000);
      @(posedge clock);
      ctl.enableCmd <= 1'b1;
      wait_for(1'b0, 1'b1, n);
      in_range(n, 1, 3);
      print_verdict();
   end
endmodule
